/* File: core/svmac_regs.svh */
// Register offsets, field positions, reset values and timing figures of the supply monitor
//
// Contract
// - Conversions are configured for and produce 8-bit results.
// - The 12-bit interval timer tick every 100 us is the hardware start trigger. Here the timer is a 15-bit counter of 20000 cycles.
// - Conversion-end interrupt only when result is at or below 0x5f.
// - After the conversion-end interrupt the lamp blinks with a 0.5 s period.
`ifndef SVMAC_REGS_SVH
`define SVMAC_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SVMAC_CTRL_OFF 8'h00
`define SVMAC_CHAN_OFF 8'h04
`define SVMAC_RESULT_OFF 8'h08
`define SVMAC_STATUS_OFF 8'h0c
`define SVMAC_MASK_OFF 8'h10
`define SVMAC_STATE_OFF 8'h14

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define SVMAC_CTRL_RESET 8'h00
`define SVMAC_CHAN_RESET 4'h0
`define SVMAC_MASK_RESET 3'h0
`define SVMAC_REF_INTERNAL 2'h2
`define SVMAC_LOW_THRESH 8'h5f
`define SVMAC_ST_LOW 0
`define SVMAC_ST_REFERR 1
`define SVMAC_ST_DONE 2
`define SVMAC_ST_W 3
`define SVMAC_RESP_OKAY 2'h0
`define SVMAC_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Timing figures
// ----------------------------------------------------------------
`define SVMAC_CLK_PERIOD_NS 5
`define SVMAC_STAB_TIME_NS 10000
`define SVMAC_INTERVAL_TIME_NS 100000
`define SVMAC_LAMP_PERIOD_NS 500000000

`endif

/* File: core/svmac_pkg.sv */
// Types shared by the supply monitor converter control
`default_nettype none
package svmac_pkg;
    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic lamp;
        logic hw_trig;
        logic one_shot;
        logic scan_mode;
        logic ref_hi;
        logic ref_lo;
        logic conv_start;
        logic comp_enable;
    } svmac_ctrl_t;

    // Requests driven toward the analogue converter
    typedef struct packed {
        logic start;
        logic enable;
        logic [1:0] ref_sel;
        logic [3:0] channel;
    } svmac_adc_req_t;

    typedef enum logic [1:0] {
        SVMAC_IDLE,
        SVMAC_SETTLE,
        SVMAC_WAIT,
        SVMAC_CONV
    } svmac_state_t;
endpackage : svmac_pkg
`default_nettype wire

/* File: core/svmac_ticker.sv */
// Free period counter that pulses once per period while running
`default_nettype none
module svmac_ticker #(
    parameter int PERIOD = 20000
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    output logic tick
);
    localparam int W = $clog2(PERIOD + 1);
    localparam logic [W-1:0] LAST = W'(PERIOD - 1);

    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic next_tick;

    // Count cycles, restart when stopped, pulse at the last count
    always_comb begin
        next_count = '0;
        next_tick = 1'b0;
        if (run) begin
            if (count == LAST) begin
                next_tick = 1'b1;
            end else begin
                next_count = count + W'(1);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule : svmac_ticker
`default_nettype wire

/* File: core/svmac_core.sv */
// Supply monitor converter control with AXI4-Lite registers
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`include "svmac_regs.svh"
`default_nettype none
module svmac_core #(
    parameter int INTERVAL_CYC = `SVMAC_INTERVAL_TIME_NS / `SVMAC_CLK_PERIOD_NS,
    parameter int LAMP_HALF_CYC = `SVMAC_LAMP_PERIOD_NS / 2 / `SVMAC_CLK_PERIOD_NS,
    parameter int RES_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic adc_done,
    input wire logic [RES_W-1:0] adc_data,
    output svmac_pkg::svmac_adc_req_t adc_req,
    output logic conversion_end_irq,
    output logic irq,
    output logic indicator_lamp
);
    localparam int STAB_CYC =
        (`SVMAC_STAB_TIME_NS + `SVMAC_CLK_PERIOD_NS - 1) / `SVMAC_CLK_PERIOD_NS;
    localparam int SW = $clog2(STAB_CYC + 1);
    localparam logic [SW-1:0] STAB_LAST = SW'(STAB_CYC - 1);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == `SVMAC_CTRL_OFF) || (a == `SVMAC_CHAN_OFF) ||
                     (a == `SVMAC_RESULT_OFF) || (a == `SVMAC_STATUS_OFF) ||
                     (a == `SVMAC_MASK_OFF) || (a == `SVMAC_STATE_OFF);
    endfunction : addr_known

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    svmac_pkg::svmac_ctrl_t ctrl, next_ctrl;
    svmac_pkg::svmac_state_t state, next_state;
    svmac_pkg::svmac_adc_req_t next_adc_req;
    logic [3:0] chan, next_chan;
    logic [RES_W-1:0] result, next_result;
    logic [`SVMAC_ST_W-1:0] status, next_status, mask, next_mask;
    logic [SW-1:0] settle_cnt, next_settle_cnt;
    logic settled, next_settled, sw_pend, next_sw_pend;
    logic aw_held, next_aw_held, w_held, next_w_held;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic w_lane0, next_w_lane0;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata, rd_word;
    logic next_end_irq, next_irq, next_lamp;
    logic trig_tick, lamp_tick, do_write, ar_take, low_hit;
    logic [`SVMAC_ST_W-1:0] st_set;
    svmac_pkg::svmac_ctrl_t wr_ctrl;

    // Interval timer that provides the hardware start trigger
    svmac_ticker #(.PERIOD(INTERVAL_CYC)) u_interval (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(ctrl.comp_enable & ctrl.conv_start & ctrl.hw_trig),
        .tick(trig_tick)
    );

    // Half-period timer for the blinking lamp
    svmac_ticker #(.PERIOD(LAMP_HALF_CYC)) u_lamp (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(ctrl.lamp),
        .tick(lamp_tick)
    );

    // Read data view of the registers
    always_comb begin
        rd_word = 32'h0000_0000;
        case (s_axi_araddr)
            `SVMAC_CTRL_OFF: rd_word[7:0] = ctrl;
            `SVMAC_CHAN_OFF: rd_word[3:0] = chan;
            `SVMAC_RESULT_OFF: rd_word[RES_W-1:0] = result;
            `SVMAC_STATUS_OFF: rd_word[`SVMAC_ST_W-1:0] = status;
            `SVMAC_MASK_OFF: rd_word[`SVMAC_ST_W-1:0] = mask;
            `SVMAC_STATE_OFF: rd_word[4:0] = {indicator_lamp, sw_pend, settled, state};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // AXI4-Lite handshakes
    // ------------------------------------------------------------
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_lane0 = w_lane0;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        do_write = 1'b0;
        ar_take = s_axi_arvalid & s_axi_arready;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_lane0 = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (aw_held && w_held && !s_axi_bvalid) begin
            do_write = 1'b1;
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = addr_known(aw_addr) ? `SVMAC_RESP_OKAY : `SVMAC_RESP_SLVERR;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (ar_take) begin
            next_rvalid = 1'b1;
            next_rdata = rd_word;
            next_rresp = addr_known(s_axi_araddr) ? `SVMAC_RESP_OKAY : `SVMAC_RESP_SLVERR;
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_lane0 <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_lane0 <= next_w_lane0;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    // ------------------------------------------------------------
    // Registers, sequencer and converter requests
    // ------------------------------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        next_chan = chan;
        next_mask = mask;
        next_result = result;
        next_state = state;
        next_settle_cnt = settle_cnt;
        next_settled = settled;
        next_sw_pend = sw_pend;
        next_end_irq = 1'b0;
        st_set = '0;
        low_hit = 1'b0;
        wr_ctrl = w_data[7:0];
        next_adc_req = adc_req;
        next_adc_req.start = 1'b0;
        // Register writes from the bus
        if (do_write && w_lane0) begin
            case (aw_addr)
                `SVMAC_CTRL_OFF: begin
                    next_ctrl = wr_ctrl;
                    if ({wr_ctrl.ref_hi, wr_ctrl.ref_lo} != {ctrl.ref_hi, ctrl.ref_lo} &&
                        (ctrl.conv_start || ctrl.comp_enable)) begin
                        next_ctrl.ref_hi = ctrl.ref_hi;
                        next_ctrl.ref_lo = ctrl.ref_lo;
                        st_set[`SVMAC_ST_REFERR] = 1'b1;
                    end
                    if (wr_ctrl.conv_start && !wr_ctrl.hw_trig) begin
                        next_sw_pend = 1'b1;
                    end
                end
                `SVMAC_CHAN_OFF: next_chan = w_data[3:0];
                `SVMAC_MASK_OFF: next_mask = w_data[`SVMAC_ST_W-1:0];
                default: next_chan = chan;
            endcase
        end
        // Conversion sequencer
        case (state)
            svmac_pkg::SVMAC_IDLE: begin
                next_settle_cnt = '0;
                next_settled = 1'b0;
                if (ctrl.comp_enable) begin
                    next_state = svmac_pkg::SVMAC_SETTLE;
                end
            end
            svmac_pkg::SVMAC_SETTLE: begin
                next_settle_cnt = settle_cnt + SW'(1);
                if (!ctrl.comp_enable) begin
                    next_state = svmac_pkg::SVMAC_IDLE;
                end else if (settle_cnt == STAB_LAST) begin
                    next_settled = 1'b1;
                    next_state = svmac_pkg::SVMAC_WAIT;
                end
            end
            svmac_pkg::SVMAC_WAIT: begin
                if (!next_ctrl.comp_enable) begin // A disabling write beats a start
                    next_state = svmac_pkg::SVMAC_IDLE;
                end else if ((ctrl.hw_trig && ctrl.conv_start && trig_tick) ||
                             (!ctrl.hw_trig && sw_pend)) begin
                    next_sw_pend = 1'b0;
                    next_adc_req.start = 1'b1;
                    next_state = svmac_pkg::SVMAC_CONV;
                end
            end
            svmac_pkg::SVMAC_CONV: begin
                if (!next_ctrl.comp_enable) begin
                    next_state = svmac_pkg::SVMAC_IDLE;
                end else if (adc_done) begin
                    next_result = adc_data;
                    st_set[`SVMAC_ST_DONE] = 1'b1;
                    low_hit = (adc_data <= RES_W'(`SVMAC_LOW_THRESH));
                    st_set[`SVMAC_ST_LOW] = low_hit;
                    next_end_irq = low_hit;
                    if (!ctrl.one_shot && !ctrl.hw_trig) begin
                        next_adc_req.start = 1'b1; // Sequential mode rearms at once
                    end else begin
                        next_state = svmac_pkg::SVMAC_WAIT;
                        if (!ctrl.hw_trig) begin
                            next_ctrl.conv_start = 1'b0;
                        end
                    end
                end
            end
            default: next_state = svmac_pkg::SVMAC_IDLE;
        endcase
        if (low_hit) begin
            next_ctrl.lamp = 1'b1;
        end
        next_status = (status & ~((do_write && w_lane0 && aw_addr == `SVMAC_STATUS_OFF) ?
                       w_data[`SVMAC_ST_W-1:0] : {`SVMAC_ST_W{1'b0}})) | st_set;
        next_irq = |(next_status & next_mask);
        next_lamp = !next_ctrl.lamp ? 1'b0 : (lamp_tick ? !indicator_lamp : indicator_lamp);
        next_adc_req.enable = next_ctrl.comp_enable;
        next_adc_req.ref_sel = {next_ctrl.ref_hi, next_ctrl.ref_lo};
        next_adc_req.channel = next_chan;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= `SVMAC_CTRL_RESET;
            chan <= `SVMAC_CHAN_RESET;
            mask <= `SVMAC_MASK_RESET;
            status <= '0;
            result <= '0;
            state <= svmac_pkg::SVMAC_IDLE;
            settle_cnt <= '0;
            settled <= 1'b0;
            sw_pend <= 1'b0;
            adc_req <= '0;
            conversion_end_irq <= 1'b0;
            irq <= 1'b0;
            indicator_lamp <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            chan <= next_chan;
            mask <= next_mask;
            status <= next_status;
            result <= next_result;
            state <= next_state;
            settle_cnt <= next_settle_cnt;
            settled <= next_settled;
            sw_pend <= next_sw_pend;
            adc_req <= next_adc_req;
            conversion_end_irq <= next_end_irq;
            irq <= next_irq;
            indicator_lamp <= next_lamp;
        end
    end
endmodule : svmac_core
`default_nettype wire

/* File: dv/svmac_monitor.sv */
// Assertion checker for the supply monitor converter control
`default_nettype none
module svmac_monitor #(
    parameter int INTERVAL_CYC = 20000,
    parameter int LAMP_HALF_CYC = 50000000,
    parameter int RES_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic adc_done,
    input wire logic [RES_W-1:0] adc_data,
    input wire svmac_pkg::svmac_adc_req_t adc_req,
    input wire logic conversion_end_irq,
    input wire logic irq
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_irq_on_low: assert property (adc_done && adc_data <= 8'h5f |=> conversion_end_irq)
        else $error("low result gave no end interrupt");
    chk_irq_cause: assert property (conversion_end_irq |->
        $past(adc_done) && $past(adc_data) <= 8'h5f)
        else $error("end interrupt without a low result");
    chk_start_pulse: assert property (adc_req.start |=> !adc_req.start)
        else $error("start longer than one cycle");
    chk_start_enabled: assert property (adc_req.start |-> adc_req.enable)
        else $error("start while comparator disabled");
    chk_ref_frozen: assert property (adc_req.enable && $past(adc_req.enable) |->
        $stable(adc_req.ref_sel))
        else $error("reference changed while enabled");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_rdata_width: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data above bit 7");

    cov_low: cover property (conversion_end_irq);
    cov_start: cover property (adc_req.start);
    cov_irq: cover property (irq);
endmodule : svmac_monitor

bind svmac_core svmac_monitor #(.INTERVAL_CYC(INTERVAL_CYC), .LAMP_HALF_CYC(LAMP_HALF_CYC),
    .RES_W(RES_W)) svmac_monitor_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .adc_done(adc_done), .adc_data(adc_data), .adc_req(adc_req),
    .conversion_end_irq(conversion_end_irq), .irq(irq));
`default_nettype wire

/* File: dv/svmac_adc_model.sv */
// Behavioural converter and supply divider facing the control block
`default_nettype none
module svmac_adc_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire svmac_pkg::svmac_adc_req_t adc_req,
    input wire logic [7:0] level,
    input wire logic [4:0] delay,
    output logic adc_done,
    output logic [7:0] adc_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] held;
    int cnt;
    // One sample per start pulse, answered after a chosen delay
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= 0;
            adc_done <= 1'h0;
            adc_data <= 8'ha5;
        end else if (adc_req.start && adc_req.enable) begin
            adc_done <= 1'h0;
            held <= level;
            cnt <= delay + 1;
        end else if (cnt == 1) begin
            adc_done <= 1'h1;
            adc_data <= held;
            cnt <= 0;
        end else begin
            adc_done <= 1'h0;
            if (cnt > 0) cnt <= cnt - 1;
            adc_data <= ~adc_data; // Not valid outside the done pulse
        end
    end
endmodule : svmac_adc_model
`default_nettype wire

/* File: dv/svmac_core_tb.sv */
// Self-checking bench for the supply monitor converter control
`default_nettype none
module svmac_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int IV = 50;
    localparam int LH = 20;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, adc_done, cirq, irq, lamp, lamp_q;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, adc_data, last_data, level = 8'h5f;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp, r;
    logic [4:0] delay = 5'h03;
    logic exp_irq = 1'h0, spacing_on = 1'h0;
    svmac_pkg::svmac_adc_req_t adc_req;
    int seed = 38, mismatches = 0, checked = 0, cyc = 0, last_start = -1, last_tog = -1;
    int n_done = 0, n_tog = 0, i, tgt;
    logic [7:0] corner [4] = '{8'h5f, 8'h60, 8'h00, 8'hff};

    always #2.5 aclk = ~aclk;

    svmac_core #(.INTERVAL_CYC(IV), .LAMP_HALF_CYC(LH), .RES_W(8)) svmac_core_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .adc_done(adc_done), .adc_data(adc_data), .adc_req(adc_req),
        .conversion_end_irq(cirq), .irq(irq), .indicator_lamp(lamp));
    svmac_adc_model svmac_adc_model_i (.aclk(aclk), .aresetn(aresetn), .adc_req(adc_req),
        .level(level), .delay(delay), .adc_done(adc_done), .adc_data(adc_data));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic low_result(input logic [7:0] v);
        return v <= 8'h5f;
    endfunction : low_result

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic timeout(input string nm);
        mismatches++;
        $display("[ERR] %s expected handshake seen none", nm);
        end_of_test();
    endtask : timeout

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        int k;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'h1;
        wdata <= v;
        wstrb <= 4'hf;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid && bready) break;
        end
        bready <= 1'h0;
        r = bresp;
        if (k == 50) timeout("write");
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        int k;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid && rready) break;
        end
        rready <= 1'h0;
        d = rdata;
        r = rresp;
        if (k == 50) timeout("read");
    endtask : axi_rd

    task automatic wait_for(input string nm, input int nd, input int nt);
        int k;
        for (k = 0; k < 5000 && (n_done < nd || n_tog < nt); k++) @(posedge aclk);
        if (k == 5000) timeout(nm);
    endtask : wait_for

    // Predict the end pulse, feed the divider, check the trigger spacing and time the lamp
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        lamp_q <= lamp;
        exp_irq <= aresetn && adc_done && low_result(adc_data);
        if (aresetn && (cirq || exp_irq)) cmp("end_irq", {31'h0, exp_irq}, {31'h0, cirq});
        if (adc_done) begin
            last_data <= adc_data;
            n_done <= n_done + 1;
            level <= (n_done < 3) ? corner[n_done+1] : 8'($random(seed));
            delay <= 5'($random(seed));
        end
        if (adc_req.start) begin
            if (spacing_on && last_start >= 0) cmp("start_gap", 32'(IV), 32'(cyc - last_start));
            last_start <= spacing_on ? cyc : -1;
        end
        if (aresetn && spacing_on && lamp !== lamp_q) begin
            if (last_tog >= 0) cmp("lamp_gap", 32'(LH), 32'(cyc - last_tog));
            last_tog <= cyc;
            n_tog <= n_tog + 1;
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        for (i = 0; i < 6; i++) begin
            axi_rd(8'(i * 4));
            cmp("reset_value", 32'h0, d);
        end
        axi_rd(8'h18);
        cmp("unmapped_rd", 32'h2, {30'h0, r});
        cmp("unmapped_data", 32'h0, d);
        axi_wr(8'h18, 32'hff);
        cmp("unmapped_wr", 32'h2, {30'h0, r});
        $display("test registers done");
        axi_wr(8'h00, 32'h08);
        cmp("ref_sel", 32'h2, {30'h0, adc_req.ref_sel});
        repeat (2000) @(posedge aclk);
        axi_wr(8'h04, 32'h5);
        cmp("channel", 32'h5, {28'h0, adc_req.channel});
        axi_wr(8'h04, 32'h0);
        cmp("channel", 32'h0, {28'h0, adc_req.channel});
        axi_wr(8'h10, 32'h7);
        axi_wr(8'h00, 32'h6b);
        spacing_on <= 1'h1;
        axi_wr(8'h00, 32'h6f);
        cmp("ref_kept", 32'h2, {30'h0, adc_req.ref_sel});
        wait_for("conversions", 12, 3);
        tgt = n_done + 1;
        wait_for("last_done", tgt, 0);
        spacing_on <= 1'h0;
        axi_wr(8'h00, 32'h08);
        $display("test triggered conversions done");
        repeat (60) @(posedge aclk);
        axi_rd(8'h08);
        cmp("result", {24'h0, last_data}, d);
        axi_rd(8'h0c);
        cmp("status", 32'h7, d);
        cmp("irq_set", 32'h1, {31'h0, irq});
        axi_wr(8'h10, 32'h4);
        axi_wr(8'h0c, 32'h4);
        @(posedge aclk);
        cmp("irq_masked", 32'h0, {31'h0, irq});
        axi_rd(8'h0c);
        cmp("status_w1c", 32'h3, d);
        $display("test interrupt done");
        // Software start in one-shot mode clears the start bit and rearms
        axi_wr(8'h00, 32'h2b);
        tgt = n_done + 1;
        wait_for("sw_start", tgt, 0);
        axi_rd(8'h00);
        cmp("one_shot_clear", 32'h29, d & 32'h7f);
        axi_rd(8'h14);
        cmp("rearm_state", 32'h6, d & 32'hf);
        $display("test software start done");
        end_of_test();
    end
endmodule : svmac_core_tb
`default_nettype wire
